// >>> tmc_defines.svh
// Register map, field positions and reset values for the timer block
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Register indexes; byte address is four times the index
`define TMC_IDX_FLAG 8'h0c
`define TMC_IDX_COUNT_LO 8'h0e
`define TMC_IDX_COUNT_HI 8'h0f
`define TMC_IDX_CTRL 8'h10
`define TMC_ADDR_FLAG (8'(`TMC_IDX_FLAG * 4))
`define TMC_ADDR_COUNT_LO (8'(`TMC_IDX_COUNT_LO * 4))
`define TMC_ADDR_COUNT_HI (8'(`TMC_IDX_COUNT_HI * 4))
`define TMC_ADDR_CTRL (8'(`TMC_IDX_CTRL * 4))

// Control field positions
`define TMC_CTRL_RUN_BIT 0
`define TMC_CTRL_SRC_BIT 1
`define TMC_CTRL_SYNC_BIT 2
`define TMC_CTRL_OSC_BIT 3
`define TMC_CTRL_PS_LSB 4
`define TMC_CTRL_PS_MSB 5
`define TMC_CTRL_WIDTH 6

// Reset values
`define TMC_CTRL_RESET 6'h00
`define TMC_COUNT_RESET 16'h0000
`define TMC_COUNT_MAX 16'hffff

// Instruction clock is the core clock divided by this
`define TMC_FOSC_DIV 4
`define TMC_DIV_LAST 2'h3

// Prescaler counter width, enough for 1:8
`define TMC_PRE_WIDTH 3

`endif

// >>> tmc_pin_src.sv
// Partner model: clock source or crystal on one count pin
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_rise,
  input wire logic [3:0] half,
  output var logic pin,
  output var logic busy
);
  logic [8:0] left; // Edges still to send
  logic [3:0] tm; // Cycles to next edge
  // Rests low between bursts, so a burst opens with a rise
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left <= {n_rise, 1'b0};
      tm <= half;
    end else if (busy && tm > 4'h1) begin
      tm <= tm - 4'h1;
    end else if (busy) begin
      pin <= !pin;
      tm <= half;
      left <= left - 9'h1;
      busy <= left > 9'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tmc_pkg.sv
// Types shared by the timer block files
package tmc_pkg;
  `include "tmc_defines.svh"

  // Control register fields, bit 0 first from the right
  typedef struct packed {
    logic [1:0] input_prescale_select;
    logic low_power_osc_enable;
    logic external_sync_bypass;
    logic count_source_select;
    logic count_run_enable;
  } tmc_ctrl_t;

  // Avalon-MM request as one bundle
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tmc_avs_req_t;

  // Prescaler state
  typedef struct packed {
    logic [`TMC_PRE_WIDTH-1:0] cnt;
  } tmc_pre_state_t;

  // Whole state of the timer top
  typedef struct packed {
    tmc_ctrl_t ctrl;
    logic [15:0] count;
    logic ovf;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] ext_sync;
    logic [2:0] osc_sync;
    logic [1:0] div;
    logic armed;
    logic pre_tgl;
    logic [2:0] isync;
    logic amp;
  } tmc_state_t;
endpackage

// >>> tmc_prescale.sv
// Input prescaler: passes one of every 1, 2, 4 or 8 steps
`timescale 1ns/1ps
`default_nettype none
module tmc_prescale
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic step,
  input wire logic [1:0] ratio,
  output logic tick
);
  tmc_pre_state_t q_q; // Registered state
  tmc_pre_state_t q_d; // Next state
  logic [`TMC_PRE_WIDTH-1:0] mask; // Low bits that must be all ones

  // Ratio code selects how many low bits gate the output
  always_comb begin
    q_d = q_q;
    unique case (ratio)
      2'h0: mask = 3'h0; // 1:1, every step passes
      2'h1: mask = 3'h1; // 1:2
      2'h2: mask = 3'h3; // 1:4
      2'h3: mask = 3'h7; // 1:8
    endcase
    // Ripple count advances on each selected input step
    tick = step && ((q_q.cnt & mask) == mask);
    if (clr) begin
      q_d.cnt = '0; // Count writes clear the divider
    end else if (step) begin
      q_d.cnt = q_q.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end
endmodule
`default_nettype wire

// >>> tmc_timer.sv
// Sixteen-bit timer/counter with control register on Avalon-MM
// How it works
// - control bits 7-6 read zero, ignore writes
// - prescale field 11/10/01 divides by 8/4/2
// - oscillator enable bit runs or stops inverter
// - external source: bit 2 one bypasses sync
// - internal source ignores the sync bit
// - source bit one external pin, zero internal
// - count advances only while run bit set
// - timer mode counts core clock over four
// - external source counts rising edges only
// - counter mode waits for one falling edge
// - oscillator enabled picks osc pin, else clock pin
// - synchronizer samples prescaler output, not pin
// - prescaler counts directly on selected input
// - sync counter mode freezes count in sleep
// - prescaler keeps counting during sleep in counter mode only
// - 16-bit count wraps ffff to 0000, sets flag
// - reset clears control: stopped, 1:1 prescale
// - writing either count byte clears prescaler
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_active,
  input wire logic osc_input_pin,
  input wire logic external_count_pin,
  output logic osc_amp_output_pin,
  output logic osc_amp_output_oe,
  output logic low_power_osc_on,
  output logic count_overflow_flag,
  output logic [15:0] count_value
);
  tmc_state_t q_q; // Registered state
  tmc_state_t q_d; // Next state
  tmc_avs_req_t req; // Bus request bundle

  // Decoded bus activity
  logic bus_req; // Read or write pending
  logic bus_take; // Edge at which the slave answers
  logic wr_take; // Write takes effect this edge
  logic wr_lo; // Write to count low byte
  logic wr_hi; // Write to count high byte
  logic wr_ctrl; // Write to control register
  logic wr_flag; // Write to flag register
  logic [31:0] rd_mux; // Read data before registering

  // Counting path
  logic instr_tick; // One pulse per instruction cycle
  logic sel_new; // Selected pin, newer agreed stage
  logic sel_old; // Selected pin, older agreed stage
  logic pin_rise; // Rising edge on selected pin
  logic pin_fall; // Falling edge on selected pin
  logic pre_step; // Step fed to the prescaler
  logic pre_tick; // Prescaler output pulse
  logic pre_clr; // Clears the prescaler
  logic sync_mode; // Synchronized counter mode
  logic count_inc; // Increment the main count

  // Bundle the bus inputs
  always_comb begin
    req.address = avs_address;
    req.read = avs_read;
    req.write = avs_write;
    req.writedata = avs_writedata;
    req.byteenable = avs_byteenable;
  end

  // Prescaler between the selected source and the count
  tmc_prescale u_pre (
    .clk(clk),
    .srst(srst),
    .clr(pre_clr),
    .step(pre_step),
    .ratio(q_q.ctrl.input_prescale_select),
    .tick(pre_tick)
  );

  // Bus decode; one wait cycle on every access
  always_comb begin
    bus_req = req.read || req.write;
    bus_take = bus_req && q_q.ack;
    wr_take = req.write && q_q.ack && req.byteenable[0];
    wr_lo = wr_take && (req.address == `TMC_ADDR_COUNT_LO);
    wr_hi = wr_take && (req.address == `TMC_ADDR_COUNT_HI);
    wr_ctrl = wr_take && (req.address == `TMC_ADDR_CTRL);
    wr_flag = wr_take && (req.address == `TMC_ADDR_FLAG);
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    unique case (req.address)
      `TMC_ADDR_CTRL: begin
        // Upper two bits are absent and read zero
        rd_mux = {26'h0, q_q.ctrl};
      end
      `TMC_ADDR_COUNT_LO: begin
        rd_mux = {24'h0, q_q.count[7:0]};
      end
      `TMC_ADDR_COUNT_HI: begin
        rd_mux = {24'h0, q_q.count[15:8]};
      end
      `TMC_ADDR_FLAG: begin
        rd_mux = {31'h0, q_q.ovf};
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // Source selection and edge detection
  always_comb begin
    // Core clock is the oscillator; divide by four
    instr_tick = (q_q.div == `TMC_DIV_LAST);
    // Oscillator pin when enabled, else clock pin
    if (q_q.ctrl.low_power_osc_enable) begin
      sel_new = q_q.osc_sync[1];
      sel_old = q_q.osc_sync[2];
    end else begin
      sel_new = q_q.ext_sync[1];
      sel_old = q_q.ext_sync[2];
    end
    // Only agreed stages are compared, never the first
    pin_rise = sel_new && !sel_old;
    pin_fall = !sel_new && sel_old;
    sync_mode = q_q.ctrl.count_source_select
      && !q_q.ctrl.external_sync_bypass;
  end

  // Prescaler feed and count increment
  always_comb begin
    pre_clr = wr_lo || wr_hi;
    pre_step = 1'b0;
    count_inc = 1'b0;
    if (q_q.ctrl.count_run_enable) begin
      if (q_q.ctrl.count_source_select) begin
        // Edges count only once armed by a falling edge
        // Pin edges still reach the divider in sleep
        pre_step = pin_rise && q_q.armed;
        if (q_q.ctrl.external_sync_bypass) begin
          // Unsynchronized path keeps running in sleep
          count_inc = pre_tick;
        end else begin
          // Agreed sync stages differ, once per cycle
          // No steps while the sync stages sleep
          count_inc = instr_tick && !sleep_active
            && (q_q.isync[1] != q_q.isync[2]);
        end
      end else begin
        // Instruction clock stops in sleep; bit 2 unused
        pre_step = instr_tick && !sleep_active;
        count_inc = pre_tick;
      end
    end
  end

  // Next-state logic for all registers
  always_comb begin
    q_d = q_q;

    // Bus handshake: answer on the second edge of a request
    q_d.ack = bus_req && !q_q.ack;
    if (bus_req && !q_q.ack) begin
      q_d.rdata = rd_mux;
    end

    // Pin synchronizers, three stages each
    q_d.ext_sync = {q_q.ext_sync[1:0], external_count_pin};
    q_d.osc_sync = {q_q.osc_sync[1:0], osc_input_pin};

    // Free-running divider for the instruction clock
    q_d.div = q_q.div + 2'h1;

    // Inverting amplifier, shut off with the enable bit
    q_d.amp = q_q.ctrl.low_power_osc_enable && !q_q.osc_sync[2];

    // Arm after a falling edge in counter mode
    if (!q_q.ctrl.count_run_enable
        || !q_q.ctrl.count_source_select) begin
      q_d.armed = 1'b0;
    end else if (pin_fall) begin
      q_d.armed = 1'b1;
    end

    // Sync sits after the prescaler; it sees its toggle
    if (sync_mode && pre_tick) begin
      q_d.pre_tgl = !q_q.pre_tgl;
    end
    if (!(sync_mode && q_q.ctrl.count_run_enable)) begin
      // Align stages so a mode change makes no false step
      q_d.isync = {3{q_q.pre_tgl}};
    end else if (instr_tick && !sleep_active) begin
      // Sampled on the instruction clock, frozen in sleep
      q_d.isync = {q_q.isync[1:0], q_q.pre_tgl};
    end

    // Main count; a software write wins over an increment
    if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        q_d.count[7:0] = req.writedata[7:0];
      end
      if (wr_hi) begin
        q_d.count[15:8] = req.writedata[7:0];
      end
    end else if (count_inc) begin
      q_d.count = q_q.count + 16'h1; // Wraps to 0000
    end

    // Overflow flag: software clears by writing zero
    if (wr_flag && !req.writedata[0]) begin
      q_d.ovf = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (!(wr_lo || wr_hi) && count_inc
        && (q_q.count == `TMC_COUNT_MAX)) begin
      q_d.ovf = 1'b1;
    end

    // Control write; bits 7-6 are dropped
    if (wr_ctrl) begin
      q_d.ctrl = tmc_ctrl_t'(req.writedata[`TMC_CTRL_WIDTH-1:0]);
    end
  end

  // State register; reset acts as power-on reset
  always_ff @(posedge clk) begin
    if (srst) begin
      q_q.ctrl <= tmc_ctrl_t'(`TMC_CTRL_RESET);
      q_q.count <= `TMC_COUNT_RESET;
      q_q.ovf <= 1'b0;
      q_q.ack <= 1'b0;
      q_q.rdata <= 32'h0;
      q_q.ext_sync <= 3'h0;
      q_q.osc_sync <= 3'h0;
      q_q.div <= 2'h0;
      q_q.armed <= 1'b0;
      q_q.pre_tgl <= 1'b0;
      q_q.isync <= 3'h0;
      q_q.amp <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  // Outputs; only waitrequest is combinational
  always_comb begin
    avs_waitrequest = bus_req && !q_q.ack;
    avs_readdata = q_q.rdata;
    // Amplifier drives the shared pin only when enabled
    osc_amp_output_pin = q_q.amp;
    osc_amp_output_oe = q_q.ctrl.low_power_osc_enable;
    low_power_osc_on = q_q.ctrl.low_power_osc_enable;
    count_overflow_flag = q_q.ovf;
    count_value = q_q.count;
  end
endmodule
`default_nettype wire

// >>> tmc_timer_props.sv
// Checker for the timer block, watching only its ports
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sleep_active,
  input wire logic osc_amp_output_pin,
  input wire logic osc_amp_output_oe,
  input wire logic low_power_osc_on,
  input wire logic count_overflow_flag,
  input wire logic [15:0] count_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Taken byte-0 writes
  wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire wc = wr && avs_address == 8'h40;
  wire wn = wr && (avs_address == 8'h38 || avs_address == 8'h3c);
  logic [5:0] ctl_q; // Shadow control field
  logic [5:0] ctl_d;
  logic [15:0] last_q; // Count one cycle back
  logic wn_q; // Count write one cycle back
  assign ctl_d = srst ? 6'h00 : wc ? avs_writedata[5:0] : ctl_q;
  // Shadow registers follow the taken writes
  always_ff @(posedge clk) begin
    ctl_q <= ctl_d;
    last_q <= count_value;
    wn_q <= wn;
  end
  wire byp = ctl_q[1] && ctl_q[2]; // Unsynchronised counting may burst
  // A software write that lands on count plus one is no step
  wire inc = count_value == last_q + 16'h1 && !wn_q;
  sequence s_rd_ctl;
    avs_read && !avs_waitrequest && avs_address == 8'h40;
  endsequence
  sequence s_wrap;
    count_value == 16'hffff ##1 count_value == 16'h0000;
  endsequence
  a_rd_top: assert property (s_rd_ctl |-> avs_readdata[31:6] == 26'h0)
    else $error("control top bits not zero");
  a_osc_follow: assert property (wc |-> ##2
    low_power_osc_on == $past(avs_writedata[3], 2))
    else $error("oscillator enable not applied");
  a_osc_off: assert property (!low_power_osc_on [*3] |->
    !osc_amp_output_pin && !osc_amp_output_oe)
    else $error("amplifier active while off");
  a_run_hold: assert property (!ctl_q[0] && !wn |=> $stable(count_value))
    else $error("count moved while stopped");
  a_wrap_flag: assert property (s_wrap |-> ##[0:1] count_overflow_flag)
    else $error("wrap did not set flag");
  a_sleep_hold: assert property (sleep_active && !byp && !wn |=>
    $stable(count_value))
    else $error("count moved in sleep");
  a_step_one: assert property (!wn |=> count_value == $past(count_value)
    || count_value == $past(count_value) + 16'h1)
    else $error("count jumped");
  a_step_gap: assert property (inc && !byp |=> !inc [*3])
    else $error("steps closer than a cycle");
  a_reset_clear: assert property ($fell(srst) |-> !low_power_osc_on
    && !count_overflow_flag && count_value == 16'h0000)
    else $error("reset state wrong");
endmodule
bind tmc_timer tmc_timer_props u_props (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .sleep_active, .osc_amp_output_pin, .osc_amp_output_oe, .low_power_osc_on,
  .count_overflow_flag, .count_value);
`default_nettype wire

// >>> tmc_timer_tb.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_tb
  import tmc_pkg::*;
;
  logic clk, srst, avs_read, avs_write, sleep_active, avs_waitrequest;
  logic [7:0] avs_address, n_r, seed;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, half;
  logic osc_amp_output_pin, osc_amp_output_oe, low_power_osc_on;
  logic count_overflow_flag, pin_x, pin_o, go_x, go_o, busy_x, busy_o;
  logic [15:0] count_value;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int err_count, check_count, t;
  // Shared pin: amplifier drives it while enabled
  wire ext_pin = osc_amp_output_oe ? osc_amp_output_pin : pin_x;
  // Counter modes: control, rising edges sent, expected count
  logic [7:0] cm [3] = '{8'h07, 8'h1f, 8'h03};
  logic [7:0] ne [3] = '{8'h06, 8'h09, 8'h06};
  logic [7:0] ce [3] = '{8'h05, 8'h04, 8'h05};
  tmc_timer dut (.clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .sleep_active, .osc_input_pin(pin_o), .external_count_pin(ext_pin),
    .osc_amp_output_pin, .osc_amp_output_oe, .low_power_osc_on,
    .count_overflow_flag, .count_value);
  tmc_pin_src u_x (.clk, .go(go_x), .n_rise(n_r), .half, .pin(pin_x),
    .busy(busy_x));
  tmc_pin_src u_o (.clk, .go(go_o), .n_rise(n_r), .half, .pin(pin_o),
    .busy(busy_o));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One bus cycle; waitrequest is sampled at the rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    // Request stands until an edge sees waitrequest low
    while (avs_waitrequest) @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Cycles between two later count steps
  task automatic gap(output int n);
    logic [15:0] v;
    @(negedge clk);
    // Second pass starts on the very cycle the first step showed
    for (int k = 0; k < 2; k++) begin
      v = count_value;
      n = 0;
      while (count_value === v && n < 99) begin
        @(negedge clk);
        n++;
      end
    end
  endtask
  // Burst of pin edges; the wait covers the sync latency
  task automatic burst(input logic o, input logic [7:0] n);
    n_r <= n;
    half <= {2'b01, seed[1:0]};
    go_x <= !o;
    go_o <= o;
    @(posedge clk);
    go_x <= 1'b0;
    go_o <= 1'b0;
    @(posedge clk);
    while (busy_x || busy_o) @(posedge clk);
    repeat (24) @(posedge clk);
    seed = lfsr(seed);
  endtask
  // Reads compared in the cycle their data stand
  always @(negedge clk) begin
    if (avs_read && !avs_waitrequest)
      chk(avs_readdata, exp_q.pop_front());
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    {srst, avs_read, avs_write, sleep_active, go_x, go_o} = 6'h20;
    {avs_address, n_r, avs_writedata} = 48'h0;
    {avs_byteenable, half, seed} = 16'hf422;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffc8);
    rd(8'h40, 32'h08);
    chk(32'({low_power_osc_on, osc_amp_output_oe, osc_amp_output_pin}), 32'h7);
    bus(1'b1, 8'h40, 32'h0);
    repeat (4) @(posedge clk);
    chk(32'({low_power_osc_on, osc_amp_output_oe, osc_amp_output_pin}), 32'h0);
    // Timer mode, each prescale code, sync bit toggled
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, 8'h38, {24'h0, seed});
      bus(1'b1, 8'h40, 32'(p * 16 + (p % 2) * 4 + 1));
      gap(t);
      chk(32'(t), 32'(4 << p));
      seed = lfsr(seed);
    end
    bus(1'b1, 8'h40, 32'h30);
    bus(1'b1, 8'h38, 32'h5a);
    repeat (40) @(posedge clk);
    rd(8'h38, 32'h5a);
    bus(1'b1, 8'h38, 32'hff);
    bus(1'b1, 8'h3c, 32'hff);
    bus(1'b1, 8'h40, 32'h01);
    repeat (12) @(posedge clk);
    bus(1'b1, 8'h40, 32'h0);
    rd(8'h30, 32'h1);
    rd(8'h3c, 32'h0);
    bus(1'b1, 8'h30, 32'h0);
    rd(8'h30, 32'h0);
    // Counter modes; first rise is ignored until a fall
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h40, 32'h0);
      bus(1'b1, 8'h38, 32'h0);
      bus(1'b1, 8'h3c, 32'h0);
      bus(1'b1, 8'h40, i < 3 ? {24'h0, cm[i]} : 32'h13);
      sleep_active <= i == 3;
      burst(i < 3 && cm[i][3], i < 3 ? ne[i] : 8'h03);
      rd(8'h38, i < 3 ? {24'h0, ce[i]} : 32'h0);
    end
    sleep_active <= 1'b0;
    // Odd step total: only a cleared divider gives one step here
    burst(1'b0, 8'h01);
    rd(8'h38, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
